// [pkg/rx_link_pkg.sv]
// Shared constants and carriers for the receive data-link block.
// Assumes one 50 MHz system clock; all line-side pins are asynchronous to it.
package rx_link_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_IRQ_CTRL = 8'h02;
	localparam logic [7:0] ADDR_CHECK_CTRL = 8'h05;
	localparam logic [7:0] ADDR_PKT_CTRL = 8'h07;
	localparam logic [7:0] ADDR_RX_CLK_CTRL = 8'h08;
	localparam logic [7:0] ADDR_LINK_STATUS = 8'h12;
	localparam logic [7:0] ADDR_FAR_ALARM_BYTE = 8'h13;

	// ==========================================================
	// Field positions
	localparam int MODE_CBITP_BIT = 0;
	localparam int MODE_E3_BIT = 1;
	localparam int IRQ_FAR_ALARM_EN_BIT = 6;
	localparam int CHECK_LONG_BIT = 2;
	localparam int STATUS_FAR_ALARM_BIT = 0;
	localparam int PKT_PARALLEL_BIT = 0;
	localparam int PKT_TRANSP_DIS_BIT = 1;
	localparam int PKT_NIBBLE_BIT = 2;
	localparam int PKT_PARTIAL_BIT = 3;
	localparam int PKT_COUNT_LSB = 4;
	localparam int CLK_JITTER_BUF_BIT = 0;

	// ==========================================================
	// Reset values and protocol constants
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] FLAG_BYTE = 8'h7E;
	localparam logic [7:0] ALARM_FLAG = 8'hFF;
	localparam logic [2:0] STUFF_ONES = 3'h5;
	localparam logic [2:0] ABORT_ONES = 3'h6;
	localparam logic [2:0] ONES_MAX = 3'h7;
	localparam logic [31:0] CRC16_POLY = 32'h00008408;
	localparam logic [31:0] LONG_CHECK_SELECT_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC16_INIT = 32'h0000FFFF;
	localparam logic [31:0] LONG_CHECK_SELECT_INIT = 32'hFFFFFFFF;
	localparam logic [2:0] FCS16_BYTES = 3'h2;
	localparam logic [2:0] FCS32_BYTES = 3'h4;
	localparam logic [4:0] DATA_COUNT_MAX = 5'h1F;

	typedef enum logic [1:0] {PH_IDLE, PH_RISE, PH_FALL} strobe_phase_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic line_serial_clock_in;
		logic fifo_serial_clock_in;
		logic serial_data;
		logic overhead_bit;
		logic cbit_mark;
		logic alarm_bit_mark;
		logic frame_align;
		logic payload_only_pin;
	} line_pins_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] rx_parallel_data;
		logic rx_byte_clock;
		logic rx_idle_indication;
		logic rx_good_check_indication;
	} par_out_t;

endpackage : rx_link_pkg

// [hw/check_byte_step.sv]
// Advances a reflected frame check value over one byte, first bit the LSB.
// Purely combinational; the caller holds the running value.
`timescale 1ns/1ps
module check_byte_step
	import rx_link_pkg::*;
(
	// Running value and byte
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data,
	input wire logic long_sel,
	// Updated value
	output logic [31:0] crc_out
);

	// ==========================================================
	// Bit-serial update unrolled over the byte
	always_comb begin
		logic [31:0] c;
		logic fb;
		c = crc_in;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			fb = c[0] ^ data[i];
			c = {1'b0, c[31:1]};
			if (fb) begin
				c = c ^ (long_sel ? LONG_CHECK_SELECT_POLY : CRC16_POLY);
			end
		end
		crc_out = c;
	end

endmodule : check_byte_step

// [hw/far_alarm_rx_channel.sv]
// Bit-oriented far-end alarm channel receiver.
// Expects one bit_valid pulse per channel bit, already synchronised.
`timescale 1ns/1ps
module far_alarm_rx_channel
	import rx_link_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Channel bits
	input wire logic bit_valid,
	input wire logic bit_value,
	// Captured message
	output logic byte_valid,
	output logic [7:0] byte_value
);

	typedef struct packed {
		logic [15:0] sr;
		logic valid;
		logic [7:0] value;
	} alarm_state_t;

	alarm_state_t s;
	alarm_state_t next_s;

	// ==========================================================
	// Pattern match, newest bit enters at the top
	always_comb begin
		logic [15:0] sr;
		sr = {bit_value, s.sr[15:1]};
		next_s = s;
		next_s.valid = 1'b0;
		if (bit_valid) begin
			next_s.sr = sr;
			if (sr[7:0] == ALARM_FLAG && !sr[8] && !sr[15]) begin
				next_s.valid = 1'b1;
				next_s.value = {<<{sr[15:8]}};
				next_s.sr = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign byte_valid = s.valid;
	assign byte_value = s.value;

endmodule : far_alarm_rx_channel

// [hw/ds3_e3_rx_datalink_and_hdlc.sv]
// Receive data link: far-end alarm channel, packet receiver, C-bit output.
// Line pins are sampled from the 50 MHz clock; serial clock must be slower.
`timescale 1ns/1ps

module ds3_e3_rx_datalink_and_hdlc
	import rx_link_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire reg_req_t req,
	output logic [7:0] rdata,
	// Line side pins
	input wire line_pins_t pins,
	// Parallel receive output
	output par_out_t par,
	// Serial C-bit output
	output logic cbit_serial_out,
	output logic cbit_out_clock,
	// Interrupt
	output logic datalink_irq_output
);

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] irq_ctrl;
		logic [7:0] check_ctrl;
		logic [7:0] pkt_ctrl;
		logic [7:0] clk_ctrl;
		logic far_alarm_irq_flag;
		logic [7:0] far_alarm_rx_byte_reg;
		logic irq_out;
		logic [7:0] rdata;
		line_pins_t sync1;
		line_pins_t sync2;
		logic clk_prev;
		logic [7:0] window;
		logic [2:0] ones;
		logic [7:0] shift;
		logic [2:0] bitcnt;
		logic synced;
		logic in_frame;
		logic [31:0] crc;
		logic [4:0] data_bytes;
		logic [2:0] frame_bytes;
		logic [3:0][7:0] hist;
		strobe_phase_t bck_phase;
		strobe_phase_t cck_phase;
		par_out_t par;
		logic cbit_out;
		logic cbit_clk;
	} rx_state_t;

	rx_state_t s;
	rx_state_t next_s;

	logic alarm_valid;
	logic [7:0] alarm_byte;
	logic [31:0] crc_next;
	logic [7:0] feed_byte;
	logic serial_fall;
	logic sel_clk;

	// ==========================================================
	// Control decode
	logic cbitp_mode;
	logic e3_mode;
	logic alarm_irq_en;
	logic long_sel;
	logic par_en;
	logic transp_dis;
	logic nibble_en;
	logic partial_en;
	logic [4:0] partial_limit;
	logic [2:0] fcs_len;

	assign cbitp_mode = s.mode[MODE_CBITP_BIT];
	assign e3_mode = s.mode[MODE_E3_BIT];
	assign alarm_irq_en = s.irq_ctrl[IRQ_FAR_ALARM_EN_BIT];
	assign long_sel = s.check_ctrl[CHECK_LONG_BIT];
	assign par_en = s.pkt_ctrl[PKT_PARALLEL_BIT];
	assign transp_dis = s.pkt_ctrl[PKT_TRANSP_DIS_BIT];
	assign nibble_en = s.pkt_ctrl[PKT_NIBBLE_BIT];
	assign partial_en = s.pkt_ctrl[PKT_PARTIAL_BIT];
	// Zero in the count field gives sixteen
	assign partial_limit = {(s.pkt_ctrl[7:4] == 4'h0), s.pkt_ctrl[7:4]};
	assign fcs_len = long_sel ? FCS32_BYTES : FCS16_BYTES;

	// Serial clock chosen by the jitter buffer enable, edge seen after sync
	assign sel_clk = s.clk_ctrl[CLK_JITTER_BUF_BIT] ? s.sync2.fifo_serial_clock_in : s.sync2.line_serial_clock_in;
	assign serial_fall = s.clk_prev & ~sel_clk;

	// Byte leaving the delay line is message data, the rest is check
	assign feed_byte = long_sel ? s.hist[3] : s.hist[1];

	// ==========================================================
	// Sub-blocks
	far_alarm_rx_channel u_alarm (
		.clk(clk),
		.arst_n(arst_n),
		.bit_valid(serial_fall & s.sync2.alarm_bit_mark & ~e3_mode),
		.bit_value(s.sync2.serial_data),
		.byte_valid(alarm_valid),
		.byte_value(alarm_byte)
	);

	check_byte_step u_check (
		.crc_in(s.crc),
		.data(feed_byte),
		.long_sel(long_sel),
		.crc_out(crc_next)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic d;
		logic payload;
		logic stuffed;
		logic flag_seen;
		logic last;
		logic fcs_ok;
		logic [2:0] cnt;
		logic [7:0] win;
		logic [7:0] sh;
		fcs_ok = 1'b0;
		next_s = s;
		d = s.sync2.serial_data;
		payload = s.sync2.payload_only_pin | ~s.sync2.overhead_bit;
		win = {d, s.window[7:1]};
		sh = {d, s.shift[7:1]};
		stuffed = ~d & (s.ones == STUFF_ONES);
		flag_seen = (win == FLAG_BYTE);
		cnt = s.bitcnt;
		last = 1'b0;
		if (long_sel) begin
			fcs_ok = ({s.hist[0], s.hist[1], s.hist[2], s.hist[3]} == ~s.crc);
		end else begin
			fcs_ok = ({s.hist[0], s.hist[1]} == ~s.crc[15:0]);
		end

		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		next_s.clk_prev = sel_clk;
		next_s.rdata = 8'h00;

		// Register access
		if (req.wr) begin
			if (req.addr == ADDR_MODE) begin
				next_s.mode = req.wdata;
			end else if (req.addr == ADDR_IRQ_CTRL) begin
				next_s.irq_ctrl = req.wdata;
			end else if (req.addr == ADDR_CHECK_CTRL) begin
				next_s.check_ctrl = req.wdata;
			end else if (req.addr == ADDR_PKT_CTRL) begin
				next_s.pkt_ctrl = req.wdata;
			end else if (req.addr == ADDR_RX_CLK_CTRL) begin
				next_s.clk_ctrl = req.wdata;
			end
		end else if (req.rd) begin
			if (req.addr == ADDR_MODE) begin
				next_s.rdata = s.mode;
			end else if (req.addr == ADDR_IRQ_CTRL) begin
				next_s.rdata = s.irq_ctrl;
			end else if (req.addr == ADDR_CHECK_CTRL) begin
				next_s.rdata = s.check_ctrl;
			end else if (req.addr == ADDR_PKT_CTRL) begin
				next_s.rdata = s.pkt_ctrl;
			end else if (req.addr == ADDR_RX_CLK_CTRL) begin
				next_s.rdata = s.clk_ctrl;
			end else if (req.addr == ADDR_LINK_STATUS) begin
				next_s.rdata[STATUS_FAR_ALARM_BIT] = s.far_alarm_irq_flag;
			end else if (req.addr == ADDR_FAR_ALARM_BYTE) begin
				next_s.rdata = s.far_alarm_rx_byte_reg;
				next_s.far_alarm_irq_flag = 1'b0;
			end
		end

		// New alarm byte; a set in the clearing cycle wins
		if (alarm_valid) begin
			next_s.far_alarm_rx_byte_reg = alarm_byte;
			if (alarm_irq_en && cbitp_mode) begin
				next_s.far_alarm_irq_flag = 1'b1;
			end
		end
		next_s.irq_out = next_s.far_alarm_irq_flag & alarm_irq_en & cbitp_mode;

		if (serial_fall) begin
			// Byte clock: rise one serial cycle after data, fall one later
			if (s.bck_phase == PH_RISE) begin
				next_s.par.rx_byte_clock = 1'b1;
				next_s.bck_phase = PH_FALL;
			end else if (s.bck_phase == PH_FALL) begin
				next_s.par.rx_byte_clock = 1'b0;
				next_s.bck_phase = PH_IDLE;
			end

			// C-bit / N-bit serial output with the same spacing
			if (s.cck_phase == PH_RISE) begin
				next_s.cbit_clk = 1'b1;
				next_s.cck_phase = PH_FALL;
			end else if (s.cck_phase == PH_FALL) begin
				next_s.cbit_clk = 1'b0;
				next_s.cck_phase = PH_IDLE;
			end
			if (s.sync2.cbit_mark && !s.sync2.payload_only_pin) begin
				next_s.cbit_out = d;
				next_s.cck_phase = PH_RISE;
			end

			if (par_en && payload && transp_dis) begin
				// Transparent mode: alignment from the frame marker
				if (s.sync2.frame_align && !s.sync2.payload_only_pin) begin
					cnt = 3'h0;
				end
				if (nibble_en) begin
					sh = {s.shift[6:0], d};
					last = (cnt[1:0] == 2'h3);
				end else begin
					last = (cnt == 3'h7);
				end
				next_s.shift = sh;
				next_s.bitcnt = last ? 3'h0 : cnt + 3'h1;
				if (last) begin
					next_s.par.rx_parallel_data = nibble_en ? {4'h0, sh[3:0]} : sh;
					next_s.bck_phase = PH_RISE;
				end
			end else if (par_en && payload) begin
				next_s.window = win;
				next_s.ones = d ? ((s.ones == ONES_MAX) ? ONES_MAX : s.ones + 3'h1) : 3'h0;
				if (d && s.ones == ABORT_ONES) begin
					next_s.in_frame = 1'b0;
					next_s.synced = 1'b0;
					next_s.par.rx_good_check_indication = 1'b1;
					next_s.par.rx_idle_indication = 1'b0;
				end
				if (!stuffed) begin
					next_s.shift = sh;
					if (flag_seen) begin
						// Flags are shown as data with their own pulse
						next_s.par.rx_parallel_data = FLAG_BYTE;
						next_s.bck_phase = PH_RISE;
						next_s.bitcnt = 3'h0;
						next_s.synced = 1'b1;
						next_s.par.rx_idle_indication = 1'b1;
						if (s.in_frame) begin
							next_s.in_frame = 1'b0;
							next_s.par.rx_good_check_indication = fcs_ok && (s.frame_bytes >= fcs_len);
						end
					end else if (s.bitcnt == 3'h7) begin
						next_s.par.rx_parallel_data = sh;
						next_s.bck_phase = PH_RISE;
						next_s.bitcnt = 3'h0;
						if (s.synced && !s.in_frame) begin
							// First byte of a message
							next_s.in_frame = 1'b1;
							next_s.par.rx_idle_indication = 1'b0;
							next_s.par.rx_good_check_indication = 1'b0;
							next_s.crc = long_sel ? LONG_CHECK_SELECT_INIT : CRC16_INIT;
							next_s.frame_bytes = 3'h1;
							next_s.data_bytes = 5'h00;
							next_s.hist = {s.hist[2:0], sh};
						end else if (s.in_frame) begin
							next_s.hist = {s.hist[2:0], sh};
							if (s.frame_bytes != ONES_MAX) begin
								next_s.frame_bytes = s.frame_bytes + 3'h1;
							end
							if (s.frame_bytes >= fcs_len && (!partial_en || s.data_bytes < partial_limit)) begin
								next_s.crc = crc_next;
								if (s.data_bytes != DATA_COUNT_MAX) begin
									next_s.data_bytes = s.data_bytes + 5'h01;
								end
							end
						end
					end else begin
						next_s.bitcnt = s.bitcnt + 3'h1;
					end
				end
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.mode <= CTRL_RESET;
			s.irq_ctrl <= CTRL_RESET;
			s.check_ctrl <= CTRL_RESET;
			s.pkt_ctrl <= CTRL_RESET;
			s.clk_ctrl <= CTRL_RESET;
			s.bck_phase <= PH_IDLE;
			s.cck_phase <= PH_IDLE;
			s.crc <= CRC16_INIT;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign rdata = s.rdata;
	assign par = s.par;
	assign cbit_serial_out = s.cbit_out;
	assign cbit_out_clock = s.cbit_clk;
	assign datalink_irq_output = s.irq_out;

endmodule : ds3_e3_rx_datalink_and_hdlc

// [sim/line_rx_model.sv]
// Behavioural line receiver: serial clocks, data and bit marks.
// Driven bit by bit by the bench; both serial clocks stand still between calls.
`timescale 1ns/1ps
module line_rx_model
	import rx_link_pkg::*;
(
	// System clock
	input wire logic clk,
	// Setup from the bench
	input wire logic sel,
	input wire logic po,
	// Pins toward the block
	output line_pins_t pins
);
	initial begin
		pins = '0;
	end

	always @(posedge clk) begin
		pins.payload_only_pin <= po;
	end

	// ==========================================================
	// One serial bit: rise, fall after four clocks, then drive the data inverted
	task automatic put_bit(input logic d, input logic ovh, input logic mk);
		@(posedge clk);
		pins.serial_data <= d;
		pins.overhead_bit <= ovh;
		pins.cbit_mark <= mk;
		pins.alarm_bit_mark <= mk;
		pins.fifo_serial_clock_in <= sel;
		pins.line_serial_clock_in <= !sel;
		repeat (4) @(posedge clk);
		pins.fifo_serial_clock_in <= 1'b0;
		pins.line_serial_clock_in <= 1'b0;
		repeat (4) @(posedge clk);
		pins.serial_data <= !d;
		pins.overhead_bit <= 1'b0;
		pins.cbit_mark <= 1'b0;
		pins.alarm_bit_mark <= 1'b0;
	endtask : put_bit
endmodule : line_rx_model

// [sim/rx_link_monitor.sv]
// Checker for the receive data-link block, bound to its top module.
// Assumes a serial clock period of at least eight system clocks.
`timescale 1ns/1ps
module rx_link_monitor
	import rx_link_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire reg_req_t req,
	input wire logic [7:0] rdata,
	// Line and outputs
	input wire line_pins_t pins,
	input wire par_out_t par,
	input wire logic cbit_serial_out,
	input wire logic cbit_out_clock,
	input wire logic datalink_irq_output
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// Shadow control bits and output hold counter
	logic cb, en, pen, both;
	logic [9:0] pv;
	logic [3:0] held;
	assign both = cb & en;
	assign pv = {par.rx_good_check_indication, par.rx_idle_indication, par.rx_parallel_data};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cb <= 1'b0;
			en <= 1'b0;
			pen <= 1'b0;
			held <= 4'h0;
		end else begin
			if (req.wr && req.addr == ADDR_MODE)
				cb <= req.wdata[MODE_CBITP_BIT];
			if (req.wr && req.addr == ADDR_IRQ_CTRL)
				en <= req.wdata[IRQ_FAR_ALARM_EN_BIT];
			if (req.wr && req.addr == ADDR_PKT_CTRL)
				pen <= req.wdata[PKT_PARALLEL_BIT];
			if (!$stable(pv))
				held <= 4'h0;
			else if (held != 4'hF)
				held <= held + 4'h1;
		end
	end

	// ==========================================================
	// Assertions
	irq_needs_both_a: assert property (datalink_irq_output |-> both || $past(both))
		else $error("irq output without enable and mode");
	rdata_quiet_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside the answer cycle");
	read_clears_irq_a: assert property (req.rd && req.addr == ADDR_FAR_ALARM_BYTE && !pins.alarm_bit_mark
		|-> ##3 !datalink_irq_output)
		else $error("byte read did not clear irq");
	status_shows_irq_a: assert property (req.rd && req.addr == ADDR_LINK_STATUS && datalink_irq_output
		&& !$past(req.rd) && !$past(req.rd, 2) |=> rdata[STATUS_FAR_ALARM_BIT])
		else $error("status flag low while irq high");
	reset_quiet_a: assert property (!$past(arst_n) |-> par == '0 && !datalink_irq_output && rdata == 8'h00)
		else $error("outputs not cleared after reset");
	bclk_width_a: assert property ($rose(par.rx_byte_clock) |-> par.rx_byte_clock[*4])
		else $error("byte clock pulse too short");
	setup_rise_a: assert property ($rose(par.rx_byte_clock) |-> held >= 4'h4)
		else $error("outputs changed too close to byte clock rise");
	hold_fall_a: assert property ($fell(par.rx_byte_clock) |-> $stable(pv)[*8])
		else $error("outputs changed too soon after byte clock fall");
	bclk_enable_a: assert property ($rose(par.rx_byte_clock) |-> pen || $past(pen, 32))
		else $error("byte clock with parallel receiver off");
	cbit_steady_a: assert property (cbit_out_clock |-> $stable(cbit_serial_out))
		else $error("C-bit output moved while its clock high");
	cbit_width_a: assert property ($rose(cbit_out_clock) |-> cbit_out_clock[*4])
		else $error("C-bit clock pulse too short");

	cover property ($rose(datalink_irq_output));
	cover property ($rose(par.rx_byte_clock) && par.rx_idle_indication && par.rx_good_check_indication);
	cover property ($rose(par.rx_good_check_indication) && !par.rx_idle_indication);
endmodule : rx_link_monitor

bind ds3_e3_rx_datalink_and_hdlc rx_link_monitor i_mon (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
	.pins(pins), .par(par), .cbit_serial_out(cbit_serial_out), .cbit_out_clock(cbit_out_clock),
	.datalink_irq_output(datalink_irq_output));

// [sim/tb_ds3_e3_rx_datalink_and_hdlc.sv]
// Self-checking bench for the receive data-link block.
// Registers driven directly; line traffic through the partner model.
`timescale 1ns/1ps
`define CHK(n, x, y) begin \
	check_count++; \
	if ((y) !== (x)) begin \
		err_count++; \
		$display("MISMATCH %s exp %h got %h", n, x, y); \
	end \
end
module tb_ds3_e3_rx_datalink_and_hdlc
	import rx_link_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	reg_req_t req = '0;
	logic [7:0] rdata;
	par_out_t par;
	logic cbit_serial_out, cbit_out_clock, datalink_irq_output;
	line_pins_t pins;
	logic sel = 1'b0;
	logic po = 1'b0;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int ones = 0;
	logic [15:0] rq[$];
	logic [19:0] bq[$];
	logic rd_q = 1'b0;
	logic bc_q = 1'b0;
	logic [19:0] e;
	logic [7:0] m8, rv, v, d;
	logic [7:0] regs [8] = '{ADDR_MODE, ADDR_IRQ_CTRL, ADDR_CHECK_CTRL, ADDR_PKT_CTRL, ADDR_RX_CLK_CTRL,
		ADDR_LINK_STATUS, ADDR_FAR_ALARM_BYTE, 8'h33};
	logic [7:0] msk [5] = '{8'h03, 8'h40, 8'h04, 8'hFF, 8'h01};

	always #10 clk = ~clk;

	ds3_e3_rx_datalink_and_hdlc i_dut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .pins(pins),
		.par(par), .cbit_serial_out(cbit_serial_out), .cbit_out_clock(cbit_out_clock),
		.datalink_irq_output(datalink_irq_output));
	line_rx_model i_line (.clk(clk), .sel(sel), .po(po), .pins(pins));

	// ==========================================================
	// Watcher: read answers and byte events against the queues
	always @(posedge clk) begin
		rd_q <= req.rd;
		bc_q <= par.rx_byte_clock;
		if (rd_q) begin
			e[15:0] = rq.pop_front();
			`CHK("rdata", e[7:0], rdata & e[15:8])
		end
		if (par.rx_byte_clock && !bc_q && bq.size() > 0) begin
			e = bq.pop_front();
			`CHK("byte", e[9:0], pv_now() & e[19:10])
		end
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end

	function automatic logic [9:0] pv_now();
		return {par.rx_good_check_indication, par.rx_idle_indication, par.rx_parallel_data};
	endfunction : pv_now

	function automatic void ex(input logic [9:0] m, input logic [9:0] x);
		bq.push_back({m, x & m});
	endfunction : ex

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b, input logic lng);
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? (lng ? LONG_CHECK_SELECT_POLY : CRC16_POLY) : 32'h0);
		return c;
	endfunction : crc_byte

	// ==========================================================
	// Register and line tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= x;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
		rq.push_back({m, x & m});
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
	endtask : rd

	// Alarm channel bit, then an unmarked overhead filler
	task automatic ab(input logic b);
		i_line.put_bit(b, 1'b0, 1'b1);
		i_line.put_bit(1'b1, 1'b1, 1'b0);
	endtask : ab

	// Byte sent first bit first, zero stuffed after five ones
	task automatic sb(input logic [7:0] b, input logic stuff);
		for (int i = 0; i < 8; i++) begin
			i_line.put_bit(b[i], 1'b0, 1'b0);
			ones = (b[i] && stuff) ? ones + 1 : 0;
			if (ones == 5) begin
				i_line.put_bit(1'b0, 1'b0, 1'b0);
				ones = 0;
			end
		end
		if (!po)
			i_line.put_bit(1'b1, 1'b1, 1'b0);
	endtask : sb

	task automatic frame(input int n, input logic lng, input logic bad);
		logic [31:0] c;
		c = lng ? LONG_CHECK_SELECT_INIT : CRC16_INIT;
		ones = 0;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom());
			c = crc_byte(c, d, lng);
			ex(10'h3FF, {2'b00, d});
			sb(d, 1'b1);
		end
		c = ~c ^ {31'h0, bad};
		for (int i = 0; i < (lng ? 4 : 2); i++) begin
			ex(10'h3FF, {2'b00, c[8*i +: 8]});
			sb(c[8*i +: 8], 1'b1);
		end
		ex(10'h3FF, {!bad, 1'b1, FLAG_BYTE});
		sb(FLAG_BYTE, 1'b0);
	endtask : frame

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h0FAB4B8C));
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		foreach (regs[i])
			rd(regs[i], 8'h00, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			v = 8'($urandom());
			wr(regs[i], v);
			rd(regs[i], v, msk[i]);
		end
		wr(ADDR_FAR_ALARM_BYTE, 8'hA5);
		rd(ADDR_FAR_ALARM_BYTE, 8'h00, 8'hFF);
		// Alarm channel: idle, then messages with mode and irq enable both on, then irq enable off, then mode off
		wr(ADDR_PKT_CTRL, 8'h00);
		wr(ADDR_RX_CLK_CTRL, 8'h00);
		wr(ADDR_MODE, 8'h01);
		wr(ADDR_IRQ_CTRL, 8'h40);
		repeat (20)
			ab(1'b1);
		`CHK("irq idle", 1'b0, datalink_irq_output)
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_MODE, {7'h0, k != 2});
			wr(ADDR_IRQ_CTRL, {1'b0, k != 1, 6'h0});
			m8 = {1'b0, 6'($urandom()), 1'b0};
			repeat (8)
				ab(1'b1);
			for (int i = 0; i < 8; i++) begin
				ab(m8[i]);
				rv[7-i] = m8[i];
			end
			repeat (20) @(posedge clk);
			`CHK("irq", k == 0, datalink_irq_output)
			`CHK("cbit", 1'b0, cbit_serial_out)
			rd(ADDR_LINK_STATUS, {7'h0, k == 0}, 8'h01);
			rd(ADDR_FAR_ALARM_BYTE, rv, 8'hFF);
			repeat (4) @(posedge clk);
			`CHK("irq clear", 1'b0, datalink_irq_output)
		end
		// Packets: good, bad, extra flag, long check over overhead, abort
		wr(ADDR_PKT_CTRL, 8'h01);
		wr(ADDR_CHECK_CTRL, 8'h00);
		po <= 1'b1;
		ones = 0;
		ex(10'h0FF, {2'b00, FLAG_BYTE});
		sb(FLAG_BYTE, 1'b0);
		frame(2, 1'b0, 1'b0);
		frame(3, 1'b0, 1'b1);
		ex(10'h1FF, {2'b01, FLAG_BYTE});
		sb(FLAG_BYTE, 1'b0);
		wr(ADDR_CHECK_CTRL, 8'h04);
		wr(ADDR_RX_CLK_CTRL, 8'h01);
		sel <= 1'b1;
		po <= 1'b0;
		frame(2, 1'b1, 1'b0);
		d = 8'($urandom());
		ones = 0;
		ex(10'h3FF, {2'b00, d});
		sb(d, 1'b1);
		ex(10'h300, 10'h200);
		sb(8'hFF, 1'b0);
		repeat (40) @(posedge clk);
		`CHK("pending", 0, bq.size())
		final_report();
	end
endmodule : tb_ds3_e3_rx_datalink_and_hdlc
